// file: rtl/msps_pkg.sv
// Package: constants, types and register map of the module state power sequencer
package msps_pkg;

  localparam int unsigned CLK_FREQ_HZ = 25000000;

  // Time figures in their own unit; cycle counts derived from the clock rate
  localparam int unsigned MGMT_INIT_TIME_US   = 2000;
  localparam int unsigned MGMT_INIT_CYCLES    = (MGMT_INIT_TIME_US * (CLK_FREQ_HZ / 1000000));
  localparam int unsigned RESETTING_TIME_US   = 20;
  localparam int unsigned RESETTING_CYCLES    = (RESETTING_TIME_US * (CLK_FREQ_HZ / 1000000));
  localparam int unsigned PWR_STEP_TIME_US    = 10;
  localparam int unsigned PWR_STEP_CYCLES     = (PWR_STEP_TIME_US * (CLK_FREQ_HZ / 1000000));
  localparam int unsigned CNT_W               = 24;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_STATUS    = 8'h04;
  localparam logic [7:0] ADDR_MAX_POWER = 8'h08;
  localparam logic [7:0] ADDR_LANES     = 8'h0c;

  // Control register fields
  localparam int unsigned CTRL_SOFT_RESET_BIT = 0;
  localparam int unsigned CTRL_LOW_POWER_BIT  = 1;
  localparam int unsigned CTRL_FLAT_BIT       = 2;
  localparam logic [31:0] CTRL_RESET_VALUE    = 32'h0000_0002;

  // Status register fields
  localparam int unsigned STAT_STATE_LSB    = 0;
  localparam int unsigned STAT_STATE_MSB    = 3;
  localparam int unsigned STAT_HIGH_PWR_BIT = 4;
  localparam int unsigned STAT_ALL_DEACT_BIT = 5;
  localparam int unsigned STAT_MEM_RST_BIT  = 6;

  localparam logic [7:0]  MAX_POWER_RESET = 8'h00;
  localparam logic [31:0] ZERO_WORD       = 32'h0000_0000;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;

  typedef enum logic [3:0] {
    MSPS_RESETTING,
    MSPS_RESET,
    MSPS_MGMT_INIT,
    MSPS_LOW_POWER,
    MSPS_POWERING_UP,
    MSPS_READY,
    MSPS_POWERING_DOWN
  } msps_state_t;

  // Reported state codes
  localparam logic [3:0] CODE_RESETTING     = 4'h0;
  localparam logic [3:0] CODE_RESET         = 4'h1;
  localparam logic [3:0] CODE_MGMT_INIT     = 4'h2;
  localparam logic [3:0] CODE_LOW_POWER     = 4'h3;
  localparam logic [3:0] CODE_POWERING_UP   = 4'h4;
  localparam logic [3:0] CODE_READY         = 4'h5;
  localparam logic [3:0] CODE_POWERING_DOWN = 4'h6;

  typedef struct packed {
    logic        sel;
    logic        write;
    logic [7:0]  addr;
  } msps_addr_phase_t;

  typedef struct packed {
    logic        high_power;
    logic        mgmt_mem_reset;
    logic        lane_reset;
    logic        mgmt_ready;
  } msps_power_ctl_t;

endpackage

// file: rtl/msps_sequencer.sv
// Module state machine: reset, management init and power mode sequencing over AHB-Lite
// Behaviour
// - Flat module walks from power-on to ready on its own, no host command.
// - Flat module always reports the ready state code.
// - Flat module under reset may hold management memory in reset; data path stays up.
// - Flat module may omit soft reset bit and supply reset input.
// - Power-on or insertion starts the state machine in Reset.
// - Reset condition forces Resetting from every state except Reset.
// - Resetting moves to Reset once electronics are down, without host action.
// - Low Power in every steady state except ready; High Power only in ready.
// - Maximum High Power figure is advertised in a dedicated byte.
// - Module leaves power-up in Low Power mode.
// - In low power, a false low-power request starts power-up.
// - Low-power condition while in or toward High Power runs power-down.
// - Low-power request affects power mode only, never data path initialisation.
// - Entering Resetting discards all per-lane data path state unless the module is flat.
// - Resetting powers down gracefully; High Power, if on at entry, persists until Reset.
// - During Resetting or reset, management accesses may be ignored.
// - Ready exit condition is low-power request and all lanes deactivated.
// - Initialisation reloads control register defaults (the code keeps a host-written flat bit); management comes up in the cycle it exits.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps

module msps_sequencer #(
  parameter int unsigned N_LANES          = 8,
  parameter bit          FLAT_MEMORY      = 1'b0,
  parameter int unsigned MGMT_INIT_CYCLES = msps_pkg::MGMT_INIT_CYCLES,
  parameter int unsigned RESETTING_CYCLES = msps_pkg::RESETTING_CYCLES,
  parameter int unsigned PWR_STEP_CYCLES  = msps_pkg::PWR_STEP_CYCLES
) (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  input  wire logic               reset_pin,
  input  wire logic               low_power_pin,
  input  wire logic [N_LANES-1:0] lane_deactivated_state,
  output logic                    high_power_en,
  output logic                    mgmt_mem_reset,
  output logic                    lane_sm_reset,
  output logic                    mgmt_ready,
  output logic [3:0]              module_state
);

  // Pin synchronisers: the first stage feeds only the second
  logic [1:0]         rst_sync_reg;
  logic [1:0]         lp_sync_reg;
  logic [N_LANES-1:0] lane_s1_reg;
  logic [N_LANES-1:0] lane_s2_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_sync_reg <= 2'h3;
      lp_sync_reg  <= 2'h3;
      lane_s1_reg  <= '1;
      lane_s2_reg  <= '1;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], reset_pin};
      lp_sync_reg  <= {lp_sync_reg[0], low_power_pin};
      lane_s1_reg  <= lane_deactivated_state;
      lane_s2_reg  <= lane_s1_reg;
    end
  end

  // Registers
  logic [31:0]          ctrl_reg;
  logic [31:0]          ctrl_next;
  logic [7:0]           max_power_reg;
  logic [7:0]           max_power_next;
  msps_pkg::msps_addr_phase_t ap_reg;
  msps_pkg::msps_addr_phase_t ap_next;
  logic [31:0]          hrdata_reg;
  logic [31:0]          hrdata_next;
  msps_pkg::msps_state_t state_reg;
  msps_pkg::msps_state_t state_next;
  logic [msps_pkg::CNT_W-1:0] cnt_reg;
  logic [msps_pkg::CNT_W-1:0] cnt_next;
  msps_pkg::msps_power_ctl_t  pwr_reg;
  msps_pkg::msps_power_ctl_t  pwr_next;

  logic flat_mode;
  logic reset_condition;
  logic low_power_request;
  logic all_lanes_deactivated;
  logic low_power_exit_condition;
  logic soft_reset_req;
  logic bus_open;

  assign flat_mode             = FLAT_MEMORY | ctrl_reg[msps_pkg::CTRL_FLAT_BIT];
  // Flat modules ignore the soft reset bit, only the pin reset_condition them
  assign soft_reset_req        = ctrl_reg[msps_pkg::CTRL_SOFT_RESET_BIT] & ~flat_mode;
  assign reset_condition       = rst_sync_reg[1] | soft_reset_req;
  assign low_power_request     = lp_sync_reg[1] | ctrl_reg[msps_pkg::CTRL_LOW_POWER_BIT];
  assign all_lanes_deactivated = &lane_s2_reg;
  assign low_power_exit_condition = low_power_request & all_lanes_deactivated;
  // Accesses are dropped while the management side is not up
  assign bus_open              = pwr_reg.mgmt_ready;

  // State machine
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end
    case (state_reg)
      msps_pkg::MSPS_RESETTING: begin
        if (cnt_reg == '0) begin
          state_next = msps_pkg::MSPS_RESET;
        end
      end
      msps_pkg::MSPS_RESET: begin
        if (!reset_condition) begin
          state_next = msps_pkg::MSPS_MGMT_INIT;
          cnt_next   = msps_pkg::CNT_W'(MGMT_INIT_CYCLES - 1);
        end
      end
      msps_pkg::MSPS_MGMT_INIT: begin
        if (cnt_reg == '0) begin
          // Flat modules go straight to ready with no host step
          state_next = flat_mode ? msps_pkg::MSPS_READY : msps_pkg::MSPS_LOW_POWER;
        end
      end
      msps_pkg::MSPS_LOW_POWER: begin
        if (!low_power_request) begin
          state_next = msps_pkg::MSPS_POWERING_UP;
          cnt_next   = msps_pkg::CNT_W'(PWR_STEP_CYCLES - 1);
        end
      end
      msps_pkg::MSPS_POWERING_UP: begin
        if (low_power_request) begin
          state_next = msps_pkg::MSPS_POWERING_DOWN;
          cnt_next   = msps_pkg::CNT_W'(PWR_STEP_CYCLES - 1);
        end else if (cnt_reg == '0) begin
          state_next = msps_pkg::MSPS_READY;
        end
      end
      msps_pkg::MSPS_READY: begin
        if (!flat_mode && low_power_exit_condition) begin
          state_next = msps_pkg::MSPS_POWERING_DOWN;
          cnt_next   = msps_pkg::CNT_W'(PWR_STEP_CYCLES - 1);
        end
      end
      msps_pkg::MSPS_POWERING_DOWN: begin
        if (cnt_reg == '0) begin
          state_next = msps_pkg::MSPS_LOW_POWER;
        end
      end
      default: begin
        state_next = msps_pkg::MSPS_RESETTING;
      end
    endcase
    if (reset_condition && state_reg != msps_pkg::MSPS_RESET && state_reg != msps_pkg::MSPS_RESETTING) begin
      state_next = msps_pkg::MSPS_RESETTING;
      cnt_next   = msps_pkg::CNT_W'(RESETTING_CYCLES - 1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= msps_pkg::MSPS_RESET;
      cnt_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // Power and reset outputs follow the next state so they change with it
  always_comb begin
    pwr_next = '0;
    case (state_next)
      msps_pkg::MSPS_RESETTING: begin
        // Graceful shutdown: high power held while it started from a high power state
        pwr_next.high_power     = pwr_reg.high_power & ~flat_mode;
        pwr_next.lane_reset     = ~flat_mode;
        pwr_next.mgmt_mem_reset = 1'b1;
      end
      msps_pkg::MSPS_RESET: begin
        // Data path of a flat module is never held in reset
        pwr_next.lane_reset     = ~flat_mode;
        pwr_next.mgmt_mem_reset = 1'b1;
      end
      msps_pkg::MSPS_MGMT_INIT: begin
        pwr_next.high_power = 1'b0;
      end
      msps_pkg::MSPS_LOW_POWER: begin
        pwr_next.mgmt_ready = 1'b1;
      end
      msps_pkg::MSPS_POWERING_UP, msps_pkg::MSPS_POWERING_DOWN: begin
        // A module switched to flat while in low power must not draw high power on its way to ready
        pwr_next.high_power = ~flat_mode;
        pwr_next.mgmt_ready = 1'b1;
      end
      msps_pkg::MSPS_READY: begin
        // A flat module stays in low power even when ready
        pwr_next.high_power = ~flat_mode;
        pwr_next.mgmt_ready = 1'b1;
      end
      default: begin
        pwr_next = '0;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwr_reg <= '{high_power: 1'b0, mgmt_mem_reset: 1'b1, lane_reset: 1'b1, mgmt_ready: 1'b0};
    end else begin
      pwr_reg <= pwr_next;
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY
  logic [3:0] state_code;

  always_comb begin
    case (state_reg)
      msps_pkg::MSPS_RESETTING:    state_code = msps_pkg::CODE_RESETTING;
      msps_pkg::MSPS_RESET:        state_code = msps_pkg::CODE_RESET;
      msps_pkg::MSPS_MGMT_INIT:    state_code = msps_pkg::CODE_MGMT_INIT;
      msps_pkg::MSPS_LOW_POWER:    state_code = msps_pkg::CODE_LOW_POWER;
      msps_pkg::MSPS_POWERING_UP:  state_code = msps_pkg::CODE_POWERING_UP;
      msps_pkg::MSPS_READY:        state_code = msps_pkg::CODE_READY;
      msps_pkg::MSPS_POWERING_DOWN: state_code = msps_pkg::CODE_POWERING_DOWN;
      default:                     state_code = msps_pkg::CODE_RESET;
    endcase
    // Flat modules hide every transient state
    if (flat_mode) begin
      state_code = msps_pkg::CODE_READY;
    end
  end

  always_comb begin
    ap_next        = '0;
    ctrl_next      = ctrl_reg;
    max_power_next = max_power_reg;
    hrdata_next    = msps_pkg::ZERO_WORD;
    if (hready) begin
      ap_next.sel   = hsel & (htrans == msps_pkg::HTRANS_NONSEQ || htrans == msps_pkg::HTRANS_SEQ);
      ap_next.write = hwrite;
      ap_next.addr  = haddr[7:0];
    end
    if (ap_reg.sel && ap_reg.write && bus_open) begin
      case (ap_reg.addr)
        msps_pkg::ADDR_CTRL:      ctrl_next = hwdata & 32'h0000_0007;
        msps_pkg::ADDR_MAX_POWER: max_power_next = hwdata[7:0];
        default:                  ctrl_next = ctrl_reg;
      endcase
    end
    // Idle or busy transfers must not load read data
    if (ap_next.sel && !hwrite && bus_open) begin
      case (haddr[7:0])
        msps_pkg::ADDR_CTRL:      hrdata_next = ctrl_reg;
        msps_pkg::ADDR_STATUS: begin
          hrdata_next[msps_pkg::STAT_STATE_MSB:msps_pkg::STAT_STATE_LSB] = state_code;
          hrdata_next[msps_pkg::STAT_HIGH_PWR_BIT]  = pwr_reg.high_power;
          hrdata_next[msps_pkg::STAT_ALL_DEACT_BIT] = all_lanes_deactivated;
          hrdata_next[msps_pkg::STAT_MEM_RST_BIT]   = pwr_reg.mgmt_mem_reset;
        end
        msps_pkg::ADDR_MAX_POWER: hrdata_next = {24'h000000, max_power_reg};
        msps_pkg::ADDR_LANES:     hrdata_next = 32'(lane_s2_reg);
        default:                  hrdata_next = msps_pkg::ZERO_WORD;
      endcase
    end
    // Soft reset self-clears once Reset is reached
    if (state_reg == msps_pkg::MSPS_RESET) begin
      ctrl_next[msps_pkg::CTRL_SOFT_RESET_BIT] = 1'b0;
    end
    // Initialisation reloads control defaults; of the control bits only the host-written flat bit survives
    if (state_reg == msps_pkg::MSPS_MGMT_INIT) begin
      ctrl_next = msps_pkg::CTRL_RESET_VALUE | (ctrl_reg & 32'h0000_0004);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_reg        <= '0;
      ctrl_reg      <= msps_pkg::CTRL_RESET_VALUE;
      max_power_reg <= msps_pkg::MAX_POWER_RESET;
      hrdata_reg    <= msps_pkg::ZERO_WORD;
    end else begin
      ap_reg        <= ap_next;
      ctrl_reg      <= ctrl_next;
      max_power_reg <= max_power_next;
      hrdata_reg    <= hrdata_next;
    end
  end

  assign hrdata         = hrdata_reg;
  assign hreadyout      = 1'b1;
  assign hresp          = 1'b0;
  // Power mode follows state only; the data path is never started here, only held in reset in Resetting and Reset
  assign high_power_en  = pwr_reg.high_power;
  assign mgmt_mem_reset = pwr_reg.mgmt_mem_reset;
  assign lane_sm_reset  = pwr_reg.lane_reset;
  assign mgmt_ready     = pwr_reg.mgmt_ready;
  assign module_state   = state_code;

endmodule // msps_sequencer

// file: test/msps_lane_model.sv
// Lane model: per-lane data path states as the far side reports them
`timescale 1ns/1ps
module msps_lane_model #(
  parameter int unsigned N_LANES = 8
) (
  input  wire logic               hclk,
  input  wire logic               lane_sm_reset,
  input  wire logic               activate,
  output logic      [N_LANES-1:0] lane_deactivated_state
);
  initial lane_deactivated_state = '1;
  // Lanes come up one at a time, so partly active sets are seen too
  always @(posedge hclk) begin
    if (lane_sm_reset || !activate) begin
      lane_deactivated_state <= '1;
    end else begin
      lane_deactivated_state <= lane_deactivated_state << 1;
    end
  end
endmodule // msps_lane_model

// file: test/msps_asserts.sv
// Checker: state and power mode relations at the sequencer ports
`timescale 1ns/1ps
module msps_asserts #(
  parameter int unsigned N_LANES          = 8,
  parameter int unsigned RESETTING_CYCLES = 8
) (
  input wire logic               hclk,
  input wire logic               hresetn,
  input wire logic               reset_pin,
  input wire logic               low_power_pin,
  input wire logic [N_LANES-1:0] lane_deactivated_state,
  input wire logic               high_power_en,
  input wire logic               mgmt_mem_reset,
  input wire logic               lane_sm_reset,
  input wire logic               mgmt_ready,
  input wire logic [3:0]         module_state
);
  // Slack covers the two-flop pin synchronisers
  localparam int RST_MAX = RESETTING_CYCLES + 6;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_steady_low;
    module_state inside {4'h1, 4'h2, 4'h3} && $stable(module_state) |-> !high_power_en;
  endproperty
  a_steady_low: assert property (p_steady_low) else $error("high power outside ready");
  property p_reset_enter;
    reset_pin [*3] |-> ##[0:RST_MAX] mgmt_mem_reset;
  endproperty
  a_reset_enter: assert property (p_reset_enter) else $error("reset not taken");
  property p_reset_hold;
    module_state == 4'h1 && reset_pin && $past(reset_pin) && $past(reset_pin, 2) |=> module_state == 4'h1;
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("left reset while held");
  property p_resetting_exit;
    module_state == 4'h0 |-> ##[1:RST_MAX] module_state == 4'h1;
  endproperty
  a_resetting_exit: assert property (p_resetting_exit) else $error("resetting did not end");
  property p_lane_discard;
    $rose(module_state == 4'h0) |-> ##[0:2] lane_sm_reset;
  endproperty
  a_lane_discard: assert property (p_lane_discard) else $error("lanes kept in resetting");
  property p_init_done;
    $past(module_state) == 4'h2 && module_state == 4'h3 |-> ##[0:1] mgmt_ready;
  endproperty
  a_init_done: assert property (p_init_done) else $error("init left without management");
  property p_ready_exit;
    (module_state == 4'h5 && low_power_pin && &lane_deactivated_state) [*3] |-> ##[1:3] module_state != 4'h5;
  endproperty
  a_ready_exit: assert property (p_ready_exit) else $error("ready kept on exit condition");
  property p_pwrup_abort;
    low_power_pin [*3] ##0 module_state == 4'h4 |-> ##[1:2] module_state inside {4'h6, 4'h0};
  endproperty
  a_pwrup_abort: assert property (p_pwrup_abort) else $error("power-up not turned back");
  c_ready: cover property (module_state == 4'h5 && high_power_en);
  c_pwrdn: cover property (module_state == 4'h6);
  c_resetting: cover property (module_state == 4'h0);
endmodule // msps_asserts

bind msps_sequencer msps_asserts #(.N_LANES(N_LANES), .RESETTING_CYCLES(RESETTING_CYCLES)) chk_u (
  .hclk(hclk), .hresetn(hresetn), .reset_pin(reset_pin), .low_power_pin(low_power_pin),
  .lane_deactivated_state(lane_deactivated_state), .high_power_en(high_power_en),
  .mgmt_mem_reset(mgmt_mem_reset), .lane_sm_reset(lane_sm_reset), .mgmt_ready(mgmt_ready),
  .module_state(module_state));

// file: test/module_state_power_sequencer_tb.sv
// Testbench: boot, bus, power mode, reset and flat mode scenarios
`timescale 1ns/1ps
module module_state_power_sequencer_tb;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  wire         hready;
  logic [31:0] hrdata;
  logic        hresp;
  logic        reset_pin = 1'b0;
  logic        low_power_pin = 1'b0;
  logic        act = 1'b0;
  logic [7:0]  lanes;
  logic        high_power_en;
  logic        mgmt_mem_reset;
  logic        lane_sm_reset;
  logic        mgmt_ready;
  logic [3:0]  module_state;
  logic [31:0] rd;
  int          n_errors = 0;
  int          checked = 0;
  int          cyc = 0;

  always #20 hclk = ~hclk;

  msps_sequencer #(.MGMT_INIT_CYCLES(16), .RESETTING_CYCLES(8), .PWR_STEP_CYCLES(6)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .reset_pin(reset_pin), .low_power_pin(low_power_pin), .lane_deactivated_state(lanes),
    .high_power_en(high_power_en), .mgmt_mem_reset(mgmt_mem_reset), .lane_sm_reset(lane_sm_reset),
    .mgmt_ready(mgmt_ready), .module_state(module_state));

  msps_lane_model lanes_u (.hclk(hclk), .lane_sm_reset(lane_sm_reset), .activate(act),
    .lane_deactivated_state(lanes));

  task automatic give_verdict();
    $display("checks %0d, errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= msps_pkg::HTRANS_NONSEQ;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    chk(hresp, 1'b0);
  endtask

  // Bounded wait for a reported state, then judged
  task automatic expect_state(input logic [3:0] code);
    int n;
    n = 0;
    while (module_state !== code && n < 200) begin
      @(posedge hclk);
      n++;
    end
    chk(module_state, code);
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    while (mgmt_ready !== 1'b1 && n < 200) begin
      @(posedge hclk);
      n++;
    end
    chk(mgmt_ready, 1'b1);
    @(posedge hclk);
  endtask

  task automatic t_boot();
    chk(module_state, msps_pkg::CODE_RESET);
    chk(mgmt_mem_reset, 1'b1);
    hresetn <= 1'b1;
    expect_state(4'h2);
    expect_state(4'h3);
    chk(high_power_en, 1'b0);
    wait_ready();
    bus(1'b0, msps_pkg::ADDR_CTRL, 32'h0);
    chk(rd, msps_pkg::CTRL_RESET_VALUE);
    bus(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, msps_pkg::ADDR_MAX_POWER, 32'ha5);
    bus(1'b0, msps_pkg::ADDR_MAX_POWER, 32'h0);
    chk(rd, 32'ha5);
  endtask

  task automatic t_power();
    act <= 1'b1;
    bus(1'b1, msps_pkg::ADDR_CTRL, 32'h0);
    expect_state(4'h4);
    expect_state(4'h5);
    @(posedge hclk);
    chk(high_power_en, 1'b1);
    low_power_pin <= 1'b1;
    repeat (20) @(posedge hclk);
    chk(module_state, 4'h5);
    chk(lane_sm_reset, 1'b0);
    bus(1'b0, msps_pkg::ADDR_STATUS, 32'h0);
    chk(rd, {25'h0, 1'b0, 1'b0, 1'b1, msps_pkg::CODE_READY});
    bus(1'b0, msps_pkg::ADDR_LANES, 32'h0);
    chk(rd, 32'h0);
    act <= 1'b0;
    expect_state(4'h6);
    expect_state(4'h3);
    @(posedge hclk);
    chk(high_power_en, 1'b0);
    low_power_pin <= 1'b0;
    expect_state(4'h4);
    low_power_pin <= 1'b1;
    expect_state(4'h6);
    expect_state(4'h3);
  endtask

  task automatic t_reset();
    low_power_pin <= 1'b0;
    act <= 1'b1;
    expect_state(4'h5);
    reset_pin <= 1'b1;
    expect_state(4'h0);
    @(posedge hclk);
    chk(lane_sm_reset, 1'b1);
    chk(high_power_en, 1'b1);
    expect_state(4'h1);
    repeat (10) @(posedge hclk);
    chk(module_state, 4'h1);
    reset_pin <= 1'b0;
    expect_state(4'h2);
    expect_state(4'h3);
    wait_ready();
    bus(1'b1, msps_pkg::ADDR_CTRL, 32'h3);
    expect_state(4'h0);
    expect_state(4'h3);
    wait_ready();
    bus(1'b0, msps_pkg::ADDR_CTRL, 32'h0);
    chk(rd, msps_pkg::CTRL_RESET_VALUE);
  endtask

  task automatic t_flat();
    bus(1'b1, msps_pkg::ADDR_CTRL, 32'h4);
    reset_pin <= 1'b1;
    for (int i = 0; i < 30; i++) begin
      @(posedge hclk);
      chk(module_state, 4'h5);
      chk(high_power_en, 1'b0);
      chk(lane_sm_reset, 1'b0);
    end
    chk(mgmt_mem_reset, 1'b1);
    reset_pin <= 1'b0;
    wait_ready();
    chk(module_state, 4'h5);
    bus(1'b0, msps_pkg::ADDR_CTRL, 32'h0);
    chk(rd[2], 1'b1);
    bus(1'b1, msps_pkg::ADDR_CTRL, 32'h5);
    repeat (4) @(posedge hclk);
    chk(mgmt_ready, 1'b1);
    chk(module_state, 4'h5);
  endtask

  // Run is a few hundred cycles; the ceiling only catches a hang
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      give_verdict();
    end
  end

  initial begin
    repeat (5) @(posedge hclk);
    t_boot();
    t_power();
    t_reset();
    t_flat();
    give_verdict();
  end
endmodule // module_state_power_sequencer_tb
